/* common/sls_pkg.sv */
package sls_pkg;

	// ----------------------------------------------------------------
	// register word indices (byte address = index * 4)
	// ----------------------------------------------------------------
	localparam logic [11:0] IDX_LINK_PAGE = 12'h300;
	localparam logic [11:0] IDX_THRESHOLD = 12'h301;
	localparam logic [11:0] IDX_IRQ_STATUS = 12'h302;
	localparam logic [11:0] IDX_IRQ_MASK = 12'h303;
	localparam logic [11:0] IDX_LANE4_STATUS = 12'h4B4;
	localparam logic [11:0] IDX_LANE5_STATUS = 12'h4B5;

	// ----------------------------------------------------------------
	// bus widths and field positions
	// ----------------------------------------------------------------
	localparam int ADDR_W = 14;
	localparam int DATA_W = 32;
	localparam int IDX_LSB = 2;
	localparam int PAGE_BIT = 0;
	localparam int LANES_PER_LINK = 2;
	localparam int IRQ_ERR_OFS = 0;
	localparam int IRQ_LOCK_OFS = 1;
	localparam int IRQ_PER_LANE = 2;

	// ----------------------------------------------------------------
	// reset values and response codes
	// ----------------------------------------------------------------
	localparam logic [7:0] THRESHOLD_RESET = 8'hFF;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic PAGE_RESET = 1'b0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECODEERROR = 2'h3;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic disparity_err;
		logic bad_symbol_err;
		logic misplaced_control_err;
		logic deskew_ok;
		logic init_align_ok;
		logic frame_lock;
		logic comma_lock;
		logic cfg_valid;
		logic cfg_last;
		logic [7:0] cfg_byte;
	} sls_lane_in_type;

	typedef struct packed {
		logic disparity_err_flag;
		logic bad_symbol_err_flag;
		logic misplaced_control_err_flag;
		logic deskew_ok;
		logic init_align_ok;
		logic config_sum_ok;
		logic frame_lock;
		logic comma_lock;
	} sls_lane_status_type;

	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ANSWER = 1'b1
	} sls_bus_state_type;

endpackage

/* rtl/sls_lane.sv */
module sls_lane #(
	parameter int CNT_W = 8
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic link_reset,
	input sls_pkg::sls_lane_in_type lane_in,
	input wire logic [7:0] error_count_threshold,
	output sls_pkg::sls_lane_status_type status
);
	import sls_pkg::*;

	// ----------------------------------------------------------------
	// error counters, one per error type
	// ----------------------------------------------------------------
	logic [2:0] err_event;
	logic [2:0] err_flag;
	logic [CNT_W-1:0] thresh_ext;
	logic [7:0] sum_q;
	logic [7:0] sum_d;
	logic sum_ok_q;
	sls_lane_status_type status_q;

	assign err_event = {lane_in.disparity_err, lane_in.bad_symbol_err, lane_in.misplaced_control_err};
	assign thresh_ext = CNT_W'(error_count_threshold);

	generate
		if (CNT_W < 8) begin : g_bad_width
			$error("sls_lane: CNT_W must be at least 8");
		end
		for (genvar e = 0; e < 3; e++) begin : g_err
			logic [CNT_W-1:0] cnt_q;
			logic sat;
			assign sat = &cnt_q;
			// saturate so a burst never wraps the flag back to clear
			always_ff @(posedge clk_sys) begin
				if (reset || link_reset) begin
					cnt_q <= '0;
				end else if (err_event[e] && !sat) begin
					cnt_q <= cnt_q + CNT_W'(1);
				end
			end
			assign err_flag[e] = (cnt_q >= thresh_ext);
		end
	endgenerate

	// ----------------------------------------------------------------
	// configuration checksum over the alignment sequence
	// ----------------------------------------------------------------
	assign sum_d = sum_q + lane_in.cfg_byte;

	always_ff @(posedge clk_sys) begin
		if (reset || link_reset) begin
			sum_q <= '0;
			sum_ok_q <= 1'b0;
		end else if (lane_in.cfg_valid && lane_in.cfg_last) begin
			sum_ok_q <= (sum_q == lane_in.cfg_byte);
			sum_q <= '0;
		end else if (lane_in.cfg_valid) begin
			sum_q <= sum_d;
		end
	end

	// ----------------------------------------------------------------
	// status byte
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			status_q <= STATUS_RESET;
		end else begin
			status_q.disparity_err_flag <= err_flag[2];
			status_q.bad_symbol_err_flag <= err_flag[1];
			status_q.misplaced_control_err_flag <= err_flag[0];
			status_q.deskew_ok <= lane_in.deskew_ok;
			status_q.init_align_ok <= lane_in.init_align_ok;
			status_q.config_sum_ok <= sum_ok_q;
			status_q.frame_lock <= lane_in.frame_lock;
			status_q.comma_lock <= lane_in.comma_lock;
		end
	end

	assign status = status_q;

endmodule

/* rtl/sls_regs.sv */
// Notes on behaviour
// - bit 7: disparity count reached threshold
// - bit 6: bad-symbol count reached threshold
// - bit 5: misplaced control count reached threshold
// - bit 4: lane deskewed against others
// - bit 3: initial alignment synchronization achieved
// - bit 2: computed configuration checksum matches
// - bit 1: frame synchronization achieved
// - bit 0: code group lock achieved
// - status read for link chosen by page
//
// Design decision made here: the Avalon-MM slave port.
module sls_regs #(
	parameter int NUM_LINKS = 2,
	parameter int CNT_W = 8
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [NUM_LINKS-1:0] link_reset,
	input sls_pkg::sls_lane_in_type lane_in [NUM_LINKS*sls_pkg::LANES_PER_LINK],
	input wire logic [sls_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [sls_pkg::DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [sls_pkg::DATA_W-1:0] avs_readdata,
	output logic [1:0] avs_response,
	output logic avs_waitrequest,
	output logic irq
);
	import sls_pkg::*;

	localparam int NUM_LANES = NUM_LINKS * LANES_PER_LINK;
	localparam int IRQ_W = NUM_LANES * IRQ_PER_LANE;

	generate
		if (NUM_LINKS < 1 || NUM_LINKS > 2) begin : g_bad_links
			$error("sls_regs: NUM_LINKS must be 1 or 2");
		end
	endgenerate

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	sls_bus_state_type bus_q;
	sls_bus_state_type bus_d;
	logic [DATA_W-1:0] rdata_q;
	logic [1:0] resp_q;
	logic irq_q;
	logic page_q;
	logic [7:0] threshold_q;
	logic [IRQ_W-1:0] irq_status_q;
	logic [IRQ_W-1:0] irq_status_d;
	logic [IRQ_W-1:0] irq_mask_q;
	sls_lane_status_type lane_status [NUM_LANES];
	sls_lane_status_type lane_prev_q [NUM_LANES];
	logic [IRQ_W-1:0] irq_event;

	// ----------------------------------------------------------------
	// per-lane status logic
	// ----------------------------------------------------------------
	generate
		for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
			logic err_now;
			logic err_before;

			sls_lane #(
				.CNT_W(CNT_W)
			) u_lane (
				.clk_sys(clk_sys),
				.reset(reset),
				.link_reset(link_reset[l / LANES_PER_LINK]),
				.lane_in(lane_in[l]),
				.error_count_threshold(threshold_q),
				.status(lane_status[l])
			);

			always_ff @(posedge clk_sys) begin
				if (reset) begin
					lane_prev_q[l] <= STATUS_RESET;
				end else begin
					lane_prev_q[l] <= lane_status[l];
				end
			end

			assign err_now = lane_status[l].disparity_err_flag | lane_status[l].bad_symbol_err_flag |
				lane_status[l].misplaced_control_err_flag;
			assign err_before = lane_prev_q[l].disparity_err_flag | lane_prev_q[l].bad_symbol_err_flag |
				lane_prev_q[l].misplaced_control_err_flag;
			// an error flag rising while none was set, and code group lock being lost
			assign irq_event[l*IRQ_PER_LANE+IRQ_ERR_OFS] = err_now & ~err_before;
			assign irq_event[l*IRQ_PER_LANE+IRQ_LOCK_OFS] = lane_prev_q[l].comma_lock & ~lane_status[l].comma_lock;
		end
	endgenerate

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	logic [11:0] word_idx;
	logic hit_page;
	logic hit_thresh;
	logic hit_irq_stat;
	logic hit_irq_mask;
	logic hit_lane4;
	logic hit_lane5;
	logic hit_any;
	logic req;
	logic accept;
	logic wr_take;
	logic wr_lane0;

	assign word_idx = avs_address[ADDR_W-1:IDX_LSB];
	assign hit_page = (word_idx == IDX_LINK_PAGE);
	assign hit_thresh = (word_idx == IDX_THRESHOLD);
	assign hit_irq_stat = (word_idx == IDX_IRQ_STATUS);
	assign hit_irq_mask = (word_idx == IDX_IRQ_MASK);
	assign hit_lane4 = (word_idx == IDX_LANE4_STATUS);
	assign hit_lane5 = (word_idx == IDX_LANE5_STATUS);
	assign hit_any = hit_page | hit_thresh | hit_irq_stat | hit_irq_mask | hit_lane4 | hit_lane5;

	assign req = avs_read | avs_write;
	// request is captured in idle, answered one cycle later
	assign accept = req && (bus_q == BUS_IDLE);
	// writes land on the edge where waitrequest is seen low
	assign wr_take = avs_write && (bus_q == BUS_ANSWER);
	assign wr_lane0 = wr_take && avs_byteenable[0];

	// ----------------------------------------------------------------
	// paged lane status
	// ----------------------------------------------------------------
	logic page_valid;
	logic [7:0] lane4_view;
	logic [7:0] lane5_view;

	// status always follows the page; a page with no link reads zero
	assign page_valid = (32'(page_q) < 32'(NUM_LINKS));
	assign lane4_view = page_valid ? lane_status[int'(page_q) * LANES_PER_LINK] : STATUS_RESET;
	assign lane5_view = page_valid ? lane_status[int'(page_q) * LANES_PER_LINK + 1] : STATUS_RESET;

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] rdata_d;

	assign rdata_d = hit_page ? DATA_W'(page_q) :
		hit_thresh ? DATA_W'(threshold_q) :
		hit_irq_stat ? DATA_W'(irq_status_q) :
		hit_irq_mask ? DATA_W'(irq_mask_q) :
		hit_lane4 ? DATA_W'(lane4_view) :
		hit_lane5 ? DATA_W'(lane5_view) : '0;

	// ----------------------------------------------------------------
	// bus handshake
	// ----------------------------------------------------------------
	always_comb begin
		bus_d = bus_q;
		unique case (bus_q)
			BUS_IDLE: begin
				if (req) begin
					bus_d = BUS_ANSWER;
				end
			end
			BUS_ANSWER: begin
				bus_d = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			bus_q <= BUS_IDLE;
		end else begin
			bus_q <= bus_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rdata_q <= '0;
			resp_q <= RESP_OKAY;
		end else if (accept) begin
			rdata_q <= avs_read ? rdata_d : '0;
			resp_q <= hit_any ? RESP_OKAY : RESP_DECODEERROR;
		end
	end

	// ----------------------------------------------------------------
	// writable registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			page_q <= PAGE_RESET;
			threshold_q <= THRESHOLD_RESET;
			irq_mask_q <= '0;
		end else if (wr_lane0) begin
			if (hit_page) begin
				page_q <= avs_writedata[PAGE_BIT];
			end
			if (hit_thresh) begin
				threshold_q <= avs_writedata[7:0];
			end
			if (hit_irq_mask) begin
				irq_mask_q <= avs_writedata[IRQ_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// interrupt status: write one to clear, a new event wins
	// ----------------------------------------------------------------
	logic [IRQ_W-1:0] irq_clear;

	assign irq_clear = (wr_lane0 && hit_irq_stat) ? avs_writedata[IRQ_W-1:0] : '0;
	assign irq_status_d = (irq_status_q & ~irq_clear) | irq_event;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			irq_status_q <= '0;
			irq_q <= 1'b0;
		end else begin
			irq_status_q <= irq_status_d;
			irq_q <= |(irq_status_d & irq_mask_q);
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign avs_readdata = rdata_q;
	assign avs_response = resp_q;
	// high in idle so no request completes without being captured
	assign avs_waitrequest = (bus_q == BUS_IDLE);
	assign irq = irq_q;

endmodule

/* tb/sls_properties.sv */
module sls_properties (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [sls_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [sls_pkg::DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [sls_pkg::DATA_W-1:0] avs_readdata,
	input wire logic [1:0] avs_response,
	input wire logic avs_waitrequest,
	input wire logic irq
);
	import sls_pkg::*;
	// ----
	// decode
	// ----
	wire logic [11:0] idx = avs_address[13:2];
	wire logic req = avs_read | avs_write;
	wire logic ans = ~avs_waitrequest;
	wire logic mapped = idx inside {IDX_LINK_PAGE, IDX_THRESHOLD, IDX_IRQ_STATUS, IDX_IRQ_MASK,
		IDX_LANE4_STATUS, IDX_LANE5_STATUS};
	wire logic mask_off = avs_write && idx == IDX_IRQ_MASK && avs_byteenable[0] && avs_writedata[7:0] == 8'h00;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	a_answer_next: assert property (req && avs_waitrequest |=> ans) else $error("no answer");
	a_answer_single: assert property (ans |=> avs_waitrequest) else $error("long answer");
	a_idle_holds: assert property (avs_waitrequest && !req |=> avs_waitrequest && $stable(avs_readdata))
		else $error("idle changed");
	a_decode_map: assert property (ans |-> (avs_response == RESP_DECODEERROR) == !mapped)
		else $error("bad response");
	a_decode_zero: assert property (ans && !mapped |-> avs_readdata == '0) else $error("unmapped data");
	a_byte_wide: assert property (ans |-> avs_readdata[31:8] == '0) else $error("upper bits");
	a_mask_quiet: assert property (ans && mask_off |-> ##2 !irq) else $error("masked irq");
	a_reset_idle: assert property (disable iff (1'b0) reset |=> avs_waitrequest && !irq && avs_readdata == '0)
		else $error("reset state");
endmodule

/* tb/sls_tx_model.sv */
module sls_tx_model (
	input wire logic clk_sys,
	output sls_pkg::sls_lane_in_type lane_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import sls_pkg::*;
	initial lane_out = '0;
	// ----
	// lane stimulus
	// ----
	task automatic pulse(input int bit_no, input int n);
		repeat (n) begin
			@(posedge clk_sys);
			lane_out[bit_no] <= 1'b1;
			@(posedge clk_sys);
			lane_out[bit_no] <= 1'b0;
		end
	endtask
	task automatic levels(input logic [3:0] v);
		@(posedge clk_sys);
		{lane_out.deskew_ok, lane_out.init_align_ok, lane_out.frame_lock, lane_out.comma_lock} <= v;
	endtask
	// bytes 11,22,33 sum to 66; bad flips the sent sum
	task automatic cfg(input logic bad);
		for (int i = 1; i <= 4; i++) begin
			@(posedge clk_sys);
			lane_out.cfg_valid <= 1'b1;
			lane_out.cfg_last <= (i == 4);
			lane_out.cfg_byte <= (i == 4) ? {7'h33, bad} : 8'(i * 17);
		end
		@(posedge clk_sys);
		lane_out.cfg_valid <= 1'b0;
		lane_out.cfg_last <= 1'b0;
		lane_out.cfg_byte <= ~lane_out.cfg_byte;
	endtask
endmodule

/* tb/serial_lane_link_status_regs_test.sv */
module serial_lane_link_status_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	import sls_pkg::*;
	`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
		$display("ERROR %s expected %h seen %h", nm, e, g); end end
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [1:0] link_reset = 2'b00;
	sls_lane_in_type lanes [4];
	logic [13:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = '0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic [1:0] avs_response;
	logic avs_waitrequest;
	logic irq;
	logic [31:0] rd;
	logic [1:0] rs;
	int miscompares = 0;
	int cmp_count = 0;
	for (genvar g = 0; g < 4; g++) begin : gl
		sls_tx_model m (.clk_sys(clk_sys), .lane_out(lanes[g]));
	end
	sls_regs DUT (.clk_sys(clk_sys), .reset(reset), .link_reset(link_reset), .lane_in(lanes),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_response(avs_response),
		.avs_waitrequest(avs_waitrequest), .irq(irq));
	initial forever #2 clk_sys = ~clk_sys;
	// ----
	// bus access
	// ----
	task automatic acc(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= {24'h0, wd};
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 64);
		if (n >= 64) miscompares++;
		rd = avs_readdata;
		rs = avs_response;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] idx, input logic [7:0] e, input string nm);
		acc(1'b0, idx, 8'h00);
		`CHK(nm, {24'h0, e}, rd)
	endtask
	function automatic logic [7:0] lv(input logic [3:0] v);
		return {3'b000, v[3], v[2], 1'b0, v[1], v[0]};
	endfunction
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// generous: the tests need well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk_sys);
		miscompares++;
		finish_test();
	end
	// ----
	// tests
	// ----
	initial begin
		repeat (16) @(posedge clk_sys);
		reset <= 1'b0;
		rdc(IDX_LANE4_STATUS, 8'h00, "s4");
		rdc(IDX_LANE5_STATUS, 8'h00, "s5");
		rdc(IDX_THRESHOLD, 8'hFF, "th");
		acc(1'b0, 12'h100, 8'h00);
		`CHK("resp", 2'h3, rs)
		$display("reset test done");
		gl[0].m.levels(4'b1010);
		gl[1].m.levels(4'b0101);
		gl[2].m.levels(4'b1111);
		gl[3].m.levels(4'b0110);
		rdc(IDX_LANE4_STATUS, lv(4'b1010), "s4p0");
		rdc(IDX_LANE5_STATUS, lv(4'b0101), "s5p0");
		acc(1'b1, IDX_LINK_PAGE, 8'h01);
		rdc(IDX_LANE4_STATUS, lv(4'b1111), "s4p1");
		rdc(IDX_LANE5_STATUS, lv(4'b0110), "s5p1");
		acc(1'b1, IDX_LINK_PAGE, 8'h00);
		$display("page test done");
		acc(1'b1, IDX_THRESHOLD, 8'h03);
		gl[0].m.pulse(16, 2);
		rdc(IDX_LANE4_STATUS, lv(4'b1010), "below");
		gl[0].m.pulse(16, 1);
		gl[1].m.pulse(15, 3);
		gl[1].m.pulse(14, 3);
		repeat (4) @(posedge clk_sys);
		rdc(IDX_LANE4_STATUS, 8'h80 | lv(4'b1010), "at");
		rdc(IDX_LANE5_STATUS, 8'h60 | lv(4'b0101), "s5e");
		`CHK("irq", 1'b0, irq)
		rdc(IDX_IRQ_STATUS, 8'h05, "ist");
		acc(1'b1, IDX_IRQ_MASK, 8'hFF);
		repeat (2) @(posedge clk_sys);
		`CHK("irq", 1'b1, irq)
		gl[1].m.levels(4'b0100);
		acc(1'b1, IDX_IRQ_STATUS, 8'h05);
		rdc(IDX_IRQ_STATUS, 8'h08, "fall");
		acc(1'b1, IDX_IRQ_STATUS, 8'h08);
		repeat (2) @(posedge clk_sys);
		`CHK("irq", 1'b0, irq)
		$display("error test done");
		gl[0].m.cfg(1'b0);
		gl[1].m.cfg(1'b1);
		repeat (4) @(posedge clk_sys);
		rdc(IDX_LANE4_STATUS, 8'h84 | lv(4'b1010), "sum");
		rdc(IDX_LANE5_STATUS, 8'h60 | lv(4'b0100), "nsum");
		link_reset <= 2'b01;
		@(posedge clk_sys);
		link_reset <= 2'b00;
		repeat (3) @(posedge clk_sys);
		rdc(IDX_LANE4_STATUS, lv(4'b1010), "c4");
		rdc(IDX_LANE5_STATUS, lv(4'b0100), "c5");
		// a write with byte 0 disabled must leave the page alone
		avs_byteenable <= 4'h0;
		acc(1'b1, IDX_LINK_PAGE, 8'h01);
		`CHK("be_resp", 2'h0, rs)
		avs_byteenable <= 4'hF;
		rdc(IDX_LANE4_STATUS, lv(4'b1010), "be_page");
		// second link: errors, interrupt, mask off, link reset
		gl[2].m.pulse(16, 3);
		repeat (4) @(posedge clk_sys);
		`CHK("irq2", 1'b1, irq)
		rdc(IDX_IRQ_STATUS, 8'h10, "ist2");
		acc(1'b1, IDX_LINK_PAGE, 8'h01);
		rdc(IDX_LANE4_STATUS, 8'h80 | lv(4'b1111), "l2err");
		acc(1'b1, IDX_IRQ_MASK, 8'h00);
		repeat (2) @(posedge clk_sys);
		`CHK("irq_off", 1'b0, irq)
		link_reset <= 2'b10;
		@(posedge clk_sys);
		link_reset <= 2'b00;
		repeat (3) @(posedge clk_sys);
		rdc(IDX_LANE4_STATUS, lv(4'b1111), "c6");
		acc(1'b1, IDX_LINK_PAGE, 8'h00);
		$display("link test done");
		$display("sum test done");
		finish_test();
	end
endmodule
bind sls_regs sls_properties u_props (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_response(avs_response), .avs_waitrequest(avs_waitrequest), .irq(irq));
